// File: sfe_front_end.sv
`timescale 1ns/1ns
// How it works
// R1: Array is 16M bytes, 64 sectors, 256-byte pages
// R2: Program per page only; erase per sector or whole
// R3: Sector n starts at n times 40000h
// R4: All bytes travel most significant bit first
// R5: First eight rising-edge bits form the opcode
// R6: Master starts each transaction with one opcode
// R7: Read-type opcodes stream data until select rises
// R8: Modifying instructions need whole-byte framing at deselect
// R9: Array access ignored while an internal cycle runs
// R10: 03h reads, 0Bh fast reads with dummy byte
// R11: 02h page program, D8h sector wipe, C7h bulk
// R12: 9Fh ident, 05h status read, 01h status write
// R13: Framed 06h sets the write enable latch
// R14: Master sends write enable before each modify
// R15: Framed 04h clears the write enable latch
// R16: Latch cleared at reset and after modify completion
// R17: Ident gives maker, type, capacity bytes in order
// R18: Ident output changes on falling clock edges
// R19: Ident opcode ignored during program or erase
// R20: Deselect returns to standby until next select
// R21: Latch clear refuses status write, program, erase
// R22: Bulk erase needs all block protection bits zero
// R23: Unknown opcode ignored, output stays undriven
// R24: Three address bytes form one 24-bit address
module sfe_front_end
  import sfe_pkg::*;
#(
  parameter logic [7:0] IDENT_MAKER = 8'hA5, // Arbitrary value
  parameter logic [7:0] IDENT_TYPE = 8'h5A, // Arbitrary value
  parameter logic [7:0] IDENT_CAPACITY = 8'h3C // Arbitrary value
) (
  input wire logic core_clk, // System clock, 100 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic selN, // Chip select pin, active low
  input wire logic sclk, // Serial clock pin from master
  input wire logic mosi, // Serial data in pin
  output logic miso, // Serial data out
  output logic misoOe, // Output enable for serial data out
  input wire logic cycleBusy, // Internal program/erase/status cycle running
  output logic [23:0] rdAddr, // Array read address
  input wire logic [7:0] rdData, // Array read data for rdAddr
  output logic pgmLoad, // Pulse: page buffer byte valid
  output logic [7:0] pgmCol, // Page column of the byte
  output logic [7:0] pgmByte, // Byte to load into page buffer
  output logic pageWriteStart, // Pulse: start page program cycle
  output logic sectorWipeStart, // Pulse: start sector erase cycle
  output logic wholeArrayWipeStart, // Pulse: start bulk erase cycle
  output logic statusWriteStart, // Pulse: start status write cycle
  output logic [23:0] cmdAddr, // Target address of modify command
  output logic writeEnableLatch, // Write enable latch state
  output logic [2:0] blockProtectionBits // Block protection setting
);

  logic selNS;
  logic sclkS;
  logic mosiS;
  logic selPrev_reg;
  logic sclkPrev_reg;
  logic busyPrev_reg;
  logic selFall;
  logic selRise;
  logic sclkRise;
  logic sclkFall;
  logic busyFall;
  sfe_phase_e phase_reg;
  logic [2:0] bitCnt_reg;
  logic [9:0] byteCnt_reg;
  logic [6:0] shiftIn_reg;
  logic [7:0] opcode_reg;
  logic [7:0] rxByte;
  logic byteDone;
  logic [23:0] addr_reg;
  logic [7:0] col_reg;
  logic [7:0] statusIn_reg;
  logic srwd_reg;
  logic welClrPending_reg;
  logic frameOk;
  logic execOk;
  logic [7:0] statusByte;
  logic [7:0] txByte;
  logic txLoad;
  logic txShift;
  logic txBit;

  // Protected when the sector sits in the top region the bits select
  function automatic logic sfeProtected(input logic [23:0] a, input logic [2:0] bp);
    logic [6:0] firstProt;
    firstProt = SECTOR_TOTAL - (ONE_SECTOR << (bp - 3'h1));
    return {1'b0, a[23:SECTOR_LSB]} >= firstProt; // [R3] [R1]
  endfunction

  // Pins cross in through the filtered synchroniser
  sfe_pin_sync #(.RESET_VAL(1'b1)) selSync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn(selN),
    .pinClean(selNS)
  );

  sfe_pin_sync #(.RESET_VAL(1'b0)) sclkSync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn(sclk),
    .pinClean(sclkS)
  );

  sfe_pin_sync #(.RESET_VAL(1'b0)) mosiSync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn(mosi),
    .pinClean(mosiS)
  );

  // Edge history of the cleaned select and clock pins and the engine busy level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      selPrev_reg <= 1'b1;
      sclkPrev_reg <= 1'b0;
      busyPrev_reg <= 1'b0;
    end else begin
      selPrev_reg <= selNS;
      sclkPrev_reg <= sclkS;
      busyPrev_reg <= cycleBusy;
    end
  end

  // Clock edges count only while selected
  assign selFall = selPrev_reg && !selNS;
  assign selRise = !selPrev_reg && selNS;
  assign sclkRise = !sclkPrev_reg && sclkS && !selNS;
  assign sclkFall = sclkPrev_reg && !sclkS && !selNS;
  assign busyFall = busyPrev_reg && !cycleBusy;
  assign rxByte = {shiftIn_reg, mosiS}; // [R4]
  assign byteDone = sclkRise && (bitCnt_reg == BIT_LAST) && (phase_reg != PH_IDLE);

  // Bit and byte counting from the first rising edge after select
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 10'h000;
      shiftIn_reg <= 7'h00;
    end else if (selFall) begin
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 10'h000;
      shiftIn_reg <= 7'h00;
    end else if (sclkRise && phase_reg != PH_IDLE) begin
      shiftIn_reg <= rxByte[6:0]; // [R4] [R5]
      bitCnt_reg <= bitCnt_reg + 3'h1;
      if (bitCnt_reg == BIT_LAST && byteCnt_reg != BYTE_CNT_MAX) begin
        byteCnt_reg <= byteCnt_reg + 10'h001; // Saturates; long pages stay legal
      end
    end
  end

  // Opcode capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      opcode_reg <= 8'h00;
    end else if (byteDone && phase_reg == PH_OPCODE) begin
      opcode_reg <= rxByte; // [R5] [R6]
    end
  end

  // Phase sequencing through opcode, address, dummy and data
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= PH_IDLE;
    end else if (selFall) begin
      phase_reg <= PH_OPCODE;
    end else if (selRise) begin
      phase_reg <= PH_IDLE; // [R20]
    end else if (byteDone) begin
      case (phase_reg)
        PH_OPCODE: begin
          case (rxByte)
            OP_ARRAY_READ, OP_FAST_READ: begin
              phase_reg <= cycleBusy ? PH_IGNORE : PH_ADDR; // [R9] [R10]
            end
            OP_PAGE_WRITE, OP_SECTOR_WIPE: phase_reg <= PH_ADDR; // [R11]
            OP_WHOLE_WIPE, OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_STATUS_WRITE: begin
              phase_reg <= PH_DATA_IN; // [R11] [R12]
            end
            OP_STATUS_READ: phase_reg <= PH_DATA_OUT; // [R12]
            OP_READ_IDENT: phase_reg <= cycleBusy ? PH_IGNORE : PH_DATA_OUT; // [R19] [R12]
            default: phase_reg <= PH_IGNORE; // [R23]
          endcase
        end
        PH_ADDR: begin
          if (byteCnt_reg == LEN_ADDR_END) begin
            case (opcode_reg)
              OP_ARRAY_READ: phase_reg <= PH_DATA_OUT; // [R10]
              OP_FAST_READ: phase_reg <= PH_DUMMY; // [R10]
              default: phase_reg <= PH_DATA_IN;
            endcase
          end
        end
        PH_DUMMY: phase_reg <= PH_DATA_OUT;
        default: phase_reg <= phase_reg; // Data phases run until deselect [R7]
      endcase
    end
  end

  // Address assembly, top byte first, and page column tracking
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= 24'h000000;
      col_reg <= 8'h00;
    end else if (byteDone && phase_reg == PH_ADDR) begin
      addr_reg <= {addr_reg[15:0], rxByte}; // [R24]
      col_reg <= rxByte;
    end else if (byteDone && phase_reg == PH_DATA_IN && opcode_reg == OP_PAGE_WRITE) begin
      col_reg <= col_reg + 8'h01; // Wraps inside the page [R2]
    end
  end

  // Page buffer feed and status byte capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pgmLoad <= 1'b0;
      pgmCol <= 8'h00;
      pgmByte <= 8'h00;
      statusIn_reg <= 8'h00;
    end else begin
      pgmLoad <= 1'b0;
      if (byteDone && phase_reg == PH_DATA_IN) begin
        if (opcode_reg == OP_PAGE_WRITE && !cycleBusy) begin
          pgmLoad <= 1'b1; // [R2] [R11] [R9]
          pgmCol <= col_reg;
          pgmByte <= rxByte;
        end
        if (opcode_reg == OP_STATUS_WRITE && byteCnt_reg == LEN_OPCODE_ONLY) begin
          statusIn_reg <= rxByte; // [R12]
        end
      end
    end
  end

  // Deselect on a byte boundary with the exact length for the opcode, or five bytes or more for page program
  always_comb begin
    case (opcode_reg)
      OP_PAGE_WRITE: frameOk = byteCnt_reg >= LEN_PAGE_MIN; // [R11]
      OP_SECTOR_WIPE: frameOk = byteCnt_reg == LEN_SECTOR_WIPE;
      OP_STATUS_WRITE: frameOk = byteCnt_reg == LEN_STATUS_WRITE; // [R12]
      OP_WHOLE_WIPE, OP_WRITE_ENABLE, OP_WRITE_DISABLE: frameOk = byteCnt_reg == LEN_OPCODE_ONLY;
      default: frameOk = 1'b0;
    endcase
  end

  assign execOk = selRise && phase_reg == PH_DATA_IN && bitCnt_reg == 3'h0 && frameOk; // [R8]

  // Modify command launch; engine busy or a clear latch refuses it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pageWriteStart <= 1'b0;
      sectorWipeStart <= 1'b0;
      wholeArrayWipeStart <= 1'b0;
      statusWriteStart <= 1'b0;
      cmdAddr <= 24'h000000;
    end else begin
      pageWriteStart <= 1'b0;
      sectorWipeStart <= 1'b0;
      wholeArrayWipeStart <= 1'b0;
      statusWriteStart <= 1'b0;
      if (execOk && writeEnableLatch && !cycleBusy) begin // [R21] [R9]
        cmdAddr <= addr_reg;
        case (opcode_reg)
          OP_PAGE_WRITE: pageWriteStart <= !sfeProtected(addr_reg, blockProtectionBits); // [R2]
          OP_SECTOR_WIPE: sectorWipeStart <= !sfeProtected(addr_reg, blockProtectionBits); // [R2]
          OP_WHOLE_WIPE: wholeArrayWipeStart <= blockProtectionBits == 3'h0; // [R22]
          OP_STATUS_WRITE: statusWriteStart <= 1'b1;
          default: cmdAddr <= addr_reg;
        endcase
      end
    end
  end

  // Status bits taken in when a status write is launched
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blockProtectionBits <= BP_RESET;
      srwd_reg <= SRWD_RESET;
    end else if (execOk && writeEnableLatch && !cycleBusy && opcode_reg == OP_STATUS_WRITE) begin
      blockProtectionBits <= statusIn_reg[ST_BP_MSB:ST_BP_LSB]; // [R21]
      srwd_reg <= statusIn_reg[ST_SRWD];
    end
  end

  // Write enable latch; modify cycles clear it when the engine finishes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      writeEnableLatch <= 1'b0; // [R16]
      welClrPending_reg <= 1'b0;
    end else begin
      if (pageWriteStart || sectorWipeStart || wholeArrayWipeStart || statusWriteStart) begin
        welClrPending_reg <= 1'b1;
      end else if (busyFall) begin
        welClrPending_reg <= 1'b0;
      end
      // A write enable landing on the cycle end wins over the clear
      if (execOk && opcode_reg == OP_WRITE_ENABLE) begin
        writeEnableLatch <= 1'b1; // [R13]
      end else if (busyFall && welClrPending_reg) begin
        writeEnableLatch <= 1'b0; // [R16]
      end else if (execOk && opcode_reg == OP_WRITE_DISABLE) begin
        writeEnableLatch <= 1'b0; // [R15] [R16]
      end
    end
  end

  assign statusByte = {srwd_reg, 2'h0, blockProtectionBits, writeEnableLatch, cycleBusy};

  // Outgoing byte for the current read-type opcode
  always_comb begin
    case (opcode_reg)
      OP_STATUS_READ: txByte = statusByte; // [R12]
      OP_READ_IDENT: begin
        case (byteCnt_reg)
          LEN_OPCODE_ONLY: txByte = IDENT_MAKER; // [R17]
          LEN_STATUS_WRITE: txByte = IDENT_TYPE; // [R17]
          LEN_IDENT: txByte = IDENT_CAPACITY; // [R17]
          default: txByte = IDENT_PAST_END;
        endcase
      end
      default: txByte = rdData; // [R10]
    endcase
  end

  // Output moves on falling edges; a new byte loads at each byte boundary
  assign txLoad = sclkFall && phase_reg == PH_DATA_OUT && bitCnt_reg == 3'h0; // [R18]
  assign txShift = sclkFall && phase_reg == PH_DATA_OUT; // [R18] [R7]

  // Read address loads from the header and steps as each byte is loaded for sending
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdAddr <= 24'h000000;
    end else if (byteDone && phase_reg == PH_ADDR && byteCnt_reg == LEN_ADDR_END) begin
      rdAddr <= {addr_reg[15:0], rxByte}; // [R24] [R10]
    end else if (txLoad && (opcode_reg == OP_ARRAY_READ || opcode_reg == OP_FAST_READ)) begin
      rdAddr <= rdAddr + 24'h000001; // Wraps at the top of the array [R24]
    end
  end

  sfe_tx_shifter txShifter (
    .core_clk(core_clk),
    .nrst(nrst),
    .loadEn(txLoad),
    .shiftEn(txShift),
    .loadByte(txByte),
    .serialOut(txBit)
  );

  // Drive the line only in an output phase; idle and ignored frames float
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      misoOe <= 1'b0;
      miso <= 1'b1;
    end else begin
      misoOe <= !selNS && phase_reg == PH_DATA_OUT; // [R23] [R20] [R7]
      miso <= txBit; // [R4]
    end
  end

endmodule

// File: sfe_pkg.sv
package sfe_pkg;

  // Array geometry
  localparam int ARRAY_BYTES = 16777216;
  localparam int SECTOR_BYTES = 262144;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_COUNT = 64;
  localparam int ADDR_W = 24;
  localparam int SECTOR_LSB = 18;
  localparam int PAGE_COL_W = 8;

  // Opcode set
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_IDENT = 8'h9F;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'hD8;
  localparam logic [7:0] OP_WHOLE_WIPE = 8'hC7;

  // Frame lengths in whole bytes, opcode included
  localparam int BYTE_CNT_W = 10;
  localparam logic [9:0] BYTE_CNT_MAX = 10'h3FF;
  localparam logic [9:0] LEN_OPCODE_ONLY = 10'h001;
  localparam logic [9:0] LEN_STATUS_WRITE = 10'h002;
  localparam logic [9:0] LEN_ADDR_END = 10'h003;
  localparam logic [9:0] LEN_SECTOR_WIPE = 10'h004;
  localparam logic [9:0] LEN_PAGE_MIN = 10'h005;
  localparam logic [9:0] LEN_IDENT = 10'h003;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Status byte layout
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_BP_MSB = 4;
  localparam int ST_SRWD = 7;
  localparam logic [2:0] BP_RESET = 3'h0;
  localparam logic SRWD_RESET = 1'b0;
  localparam logic [7:0] IDENT_PAST_END = 8'h00;

  // Protection arithmetic
  localparam logic [6:0] SECTOR_TOTAL = 7'h40;
  localparam logic [6:0] ONE_SECTOR = 7'h01;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA_IN,
    PH_DATA_OUT,
    PH_IGNORE
  } sfe_phase_e;

endpackage

// File: sfe_pin_sync.sv
`timescale 1ns/1ns
module sfe_pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic pinIn, // Raw pin level
  output logic pinClean // Filtered level
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // Three flops; the first feeds only the second to contain metastability
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // A change is taken only once the last two stages agree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinClean <= RESET_VAL;
    end else if (stage2_reg == stage3_reg) begin
      pinClean <= stage3_reg;
    end
  end

endmodule

// File: sfe_tx_shifter.sv
`timescale 1ns/1ns
module sfe_tx_shifter (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic loadEn, // Load a fresh byte
  input wire logic shiftEn, // Advance one bit
  input wire logic [7:0] loadByte, // Byte to send
  output logic serialOut // Current output bit
);

  logic [7:0] shift_reg;

  // Byte goes out top bit first; idle line rests high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg <= 8'hFF;
    end else if (loadEn) begin
      shift_reg <= loadByte;
    end else if (shiftEn) begin
      shift_reg <= {shift_reg[6:0], 1'b1};
    end
  end

  assign serialOut = shift_reg[7];

endmodule

// File: sfe_front_end_asserts.sv
`timescale 1ns/1ns
module sfe_front_end_asserts (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic selN, // Select pin
  input wire logic sclk, // Serial clock pin
  input wire logic miso, // Serial out
  input wire logic misoOe, // Out enable
  input wire logic cycleBusy, // Engine busy
  input wire logic pgmLoad, // Page byte strobe
  input wire logic pageWriteStart, // Launch
  input wire logic sectorWipeStart, // Launch
  input wire logic wholeArrayWipeStart, // Launch
  input wire logic statusWriteStart, // Launch
  input wire logic writeEnableLatch, // Latch
  input wire logic [2:0] blockProtectionBits // Protection
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic anyStart;
  // Any launch; the engine takes one command at a time
  assign anyStart = pageWriteStart | sectorWipeStart | wholeArrayWipeStart | statusWriteStart;
  // Deselected long enough for the pin synchroniser and output turn-off
  sequence s_idle;
    selN [*8] ##1 selN ##1 selN;
  endsequence
  sequence s_launch;
    anyStart;
  endsequence
  property p_quiet; s_idle |-> !misoOe; endproperty
  a_quiet: assert property (p_quiet) else $error("output driven while deselected");
  property p_wel; s_launch |-> writeEnableLatch; endproperty
  a_wel: assert property (p_wel) else $error("launch with latch clear");
  property p_bulk; wholeArrayWipeStart |-> blockProtectionBits == 3'h0; endproperty
  a_bulk: assert property (p_bulk) else $error("bulk wipe while protected");
  property p_busy; s_launch |-> !cycleBusy; endproperty
  a_busy: assert property (p_busy) else $error("launch during busy cycle");
  property p_frame; s_launch |-> selN; endproperty
  a_frame: assert property (p_frame) else $error("launch before deselect");
  property p_once; s_launch |=> !anyStart [*8]; endproperty
  a_once: assert property (p_once) else $error("repeated launch");
  property p_clear; $fell(cycleBusy) |-> ##[0:4] !writeEnableLatch; endproperty
  a_clear: assert property (p_clear) else $error("latch kept after cycle");
  property p_set; $rose(writeEnableLatch) |-> selN; endproperty
  a_set: assert property (p_set) else $error("latch set while selected");
  property p_load; pgmLoad |-> !selN && !cycleBusy; endproperty
  a_load: assert property (p_load) else $error("page byte out of frame");
  // Output may only move while the serial clock is low, after a fall
  property p_edge; misoOe && $past(misoOe) && $changed(miso) |-> !sclk; endproperty
  a_edge: assert property (p_edge) else $error("output moved with clock high");
endmodule
bind sfe_front_end sfe_front_end_asserts u_sfe_front_end_asserts (
  .core_clk, .nrst, .selN, .sclk, .miso, .misoOe, .cycleBusy, .pgmLoad, .pageWriteStart,
  .sectorWipeStart, .wholeArrayWipeStart, .statusWriteStart, .writeEnableLatch,
  .blockProtectionBits
);

// File: sfe_spi_master.sv
`timescale 1ns/1ns
module sfe_spi_master #(
  parameter int HALF = 8 // Core cycles per serial half period
) (
  input wire logic core_clk, // System clock
  output logic selN, // Select, active low
  output logic sclk, // Serial clock, idles low
  output logic mosi, // Data to the device
  input wire logic miso // Data from the device
);
  // Idle: deselected, clock parked low
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // One instruction per select; the opcode is the leading byte of tx
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    @(posedge core_clk);
    selN <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (HALF) @(posedge core_clk);
      rx[i] = miso;
      sclk <= 1'b1;
      repeat (HALF) @(posedge core_clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge core_clk);
    selN <= 1'b1;
    // Undriven data line must not look like a held value
    mosi <= ~mosi;
    repeat (4 * HALF) @(posedge core_clk);
  endtask
endmodule

// File: tb_serial_flash_instruction_front_end.sv
`timescale 1ns/1ns
`define CHK(what, exp, act) begin check_count++; if ((act) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, act); end end
module tb_serial_flash_instruction_front_end;
  import sfe_pkg::*;
  localparam logic [7:0] MAKER = 8'h6B; // Arbitrary value
  localparam logic [7:0] MTYPE = 8'h2D; // Arbitrary value
  localparam logic [7:0] CAPAC = 8'h71; // Arbitrary value
  localparam logic [7:0] KEY = 8'h5A;
  localparam int LIMIT = 60000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic selN, sclk, mosi, miso, misoOe, pgmLoad, writeEnableLatch;
  logic pageWriteStart, sectorWipeStart, wholeArrayWipeStart, statusWriteStart;
  logic cycleBusy = 1'b0;
  logic forceBusy = 1'b0;
  logic [7:0] rdData = 8'h00;
  logic [7:0] pgmCol, pgmByte;
  logic [23:0] rdAddr, cmdAddr;
  logic [2:0] blockProtectionBits;
  logic [63:0] rxv;
  logic [15:0] loads [$];
  int busyCnt = 0;
  int oeCnt = 0;
  int cyc = 0;
  int num_errors = 0;
  int check_count = 0;
  int startCnt [4] = '{0, 0, 0, 0};
  always #5 core_clk = ~core_clk;
  sfe_front_end #(.IDENT_MAKER(MAKER), .IDENT_TYPE(MTYPE), .IDENT_CAPACITY(CAPAC)) u_sfe_front_end (
    .core_clk, .nrst, .selN, .sclk, .mosi, .miso, .misoOe, .cycleBusy, .rdAddr, .rdData,
    .pgmLoad, .pgmCol, .pgmByte, .pageWriteStart, .sectorWipeStart, .wholeArrayWipeStart,
    .statusWriteStart, .cmdAddr, .writeEnableLatch, .blockProtectionBits
  );
  // Released data line shows the inverse so a floating output cannot pass
  logic misoLine;
  assign misoLine = misoOe ? miso : ~miso;
  sfe_spi_master u_sfe_spi_master (.core_clk, .selN, .sclk, .mosi, .miso(misoLine));
  // Engine stand-in and array model; busy is 30 cycles so waits stay short
  always @(posedge core_clk) begin
    if (pageWriteStart | sectorWipeStart | wholeArrayWipeStart | statusWriteStart) begin
      busyCnt <= 30;
    end else if (busyCnt != 0) begin
      busyCnt <= busyCnt - 1;
    end
    cycleBusy <= forceBusy || busyCnt > 1 || pageWriteStart || sectorWipeStart
      || wholeArrayWipeStart || statusWriteStart;
    rdData <= rdAddr[7:0] ^ KEY;
    oeCnt <= oeCnt + int'(misoOe);
    if (pgmLoad) loads.push_back({pgmCol, pgmByte});
    startCnt[0] <= startCnt[0] + int'(pageWriteStart);
    startCnt[1] <= startCnt[1] + int'(sectorWipeStart);
    startCnt[2] <= startCnt[2] + int'(wholeArrayWipeStart);
    startCnt[3] <= startCnt[3] + int'(statusWriteStart);
    cyc <= cyc + 1;
  end
  // Hang guard
  always @(posedge core_clk) begin
    if (cyc == LIMIT) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic send(input int n, input logic [63:0] v);
    u_sfe_spi_master.frame(n, v, rxv);
  endtask
  task automatic write_enable_cmd();
    send(8, 64'h06);
  endtask
  // Bounded wait for the engine, then time for the latch to clear
  task automatic settle();
    repeat (200) if (cycleBusy !== 1'b0) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic t_ident();
    send(40, 64'h9F00000000);
    `CHK("ident", {MAKER, MTYPE, CAPAC, IDENT_PAST_END}, rxv[31:0])
  endtask
  task automatic t_wel();
    int oe0;
    write_enable_cmd();
    `CHK("latch set", 1'b1, writeEnableLatch)
    send(8, 64'h04);
    `CHK("latch clear", 1'b0, writeEnableLatch)
    send(9, 64'h0C);
    `CHK("nine clocks", 1'b0, writeEnableLatch)
    write_enable_cmd();
    send(7, 64'h02);
    `CHK("seven clocks", 1'b1, writeEnableLatch)
    send(8, 64'h04);
    oe0 = oeCnt;
    send(16, 64'hFF00);
    `CHK("unknown op", oe0, oeCnt)
  endtask
  task automatic t_page();
    loads.delete();
    write_enable_cmd();
    send(56, 64'h021234FEA1B2C3);
    `CHK("page start", 1, startCnt[0])
    `CHK("page addr", 24'h1234FE, cmdAddr)
    `CHK("page bytes", 3, loads.size())
    `CHK("col FE", 16'hFEA1, loads[0])
    `CHK("col FF", 16'hFFB2, loads[1])
    `CHK("col 00", 16'h00C3, loads[2])
    settle();
    `CHK("latch after page", 1'b0, writeEnableLatch)
    send(56, 64'h021234FEA1B2C3);
    `CHK("no latch", 1, startCnt[0])
  endtask
  task automatic t_wipe();
    write_enable_cmd();
    send(33, 64'h1B1F80000);
    `CHK("odd wipe", 0, startCnt[1])
    send(32, 64'hD8FC0000);
    `CHK("wipe start", 1, startCnt[1])
    `CHK("wipe addr", 24'hFC0000, cmdAddr)
    settle();
  endtask
  task automatic t_status();
    write_enable_cmd();
    send(16, 64'h010C);
    `CHK("status start", 1, startCnt[3])
    `CHK("protect", 3'h3, blockProtectionBits)
    settle();
    send(16, 64'h0500);
    `CHK("status read", 8'h0C, rxv[7:0])
    write_enable_cmd();
    send(8, 64'hC7);
    `CHK("bulk protected", 0, startCnt[2])
    send(32, 64'hD8FC0000);
    `CHK("wipe protected", 1, startCnt[1])
    send(16, 64'h0100);
    settle();
    write_enable_cmd();
    send(8, 64'hC7);
    `CHK("bulk start", 1, startCnt[2])
    settle();
  endtask
  task automatic t_read();
    send(56, 64'h03FFFFFE000000);
    `CHK("read", {8'hFE ^ KEY, 8'hFF ^ KEY, 8'h00 ^ KEY}, rxv[23:0])
    send(48, 64'h0B000010FF00);
    `CHK("fast read", 8'h10 ^ KEY, rxv[7:0])
  endtask
  // Reads and launches while the engine is held busy
  task automatic t_busy();
    int oe0;
    @(posedge core_clk);
    forceBusy <= 1'b1;
    repeat (4) @(posedge core_clk);
    oe0 = oeCnt;
    send(40, 64'h9F00000000);
    send(56, 64'h03000000000000);
    `CHK("busy output", oe0, oeCnt)
    write_enable_cmd();
    send(32, 64'hD8000000);
    `CHK("busy wipe", 1, startCnt[1])
    send(8, 64'h04);
    @(posedge core_clk);
    forceBusy <= 1'b0;
    settle();
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_ident();
    t_wel();
    t_page();
    t_wipe();
    t_status();
    t_read();
    t_busy();
    results();
  end
endmodule
